// *** inc/frame_timing_pkg.sv ***
// Purpose: constants for the frame number and periodic start timing block
// Assumes: 100 MHz clk, full-speed bit time of 12 Mbit/s
// Notes: register offsets are byte offsets from the memory base address
//
// Contract
// - frame count advances each time the remaining counter reloads.
// - frame count wraps to zero after its maximum value.
// - frame count advances on entry to the operational bus state.
// - per frame: count, send start token, store count, then fetch descriptor.
// - after the shared area write, set start-of-frame flag bit 2.
// - hardware reset clears the periodic start threshold.
// - at threshold, periodic lists take priority for the rest of the frame.
// - in-progress control or bulk transaction finishes before interrupt list.
// - frame number register at offset 3c, count in bits 13..0.
// - periodic start register at offset 40, threshold bits 13..0, reset zero.
// - remaining counter decrements per bit time, reloads after reaching zero.
// - interval field holds bit times per frame minus one, nominal 11999.
package frame_timing_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFF_FRAME_NUMBER = 8'h3c;
  localparam logic [ADDR_W-1:0] OFF_PERIODIC_START = 8'h40;
  localparam int unsigned COUNT_W = 14;
  localparam logic [COUNT_W-1:0] FRAME_NUMBER_RESET = 14'h0000;
  localparam logic [COUNT_W-1:0] PERIODIC_START_RESET = 14'h0000;
  localparam logic [COUNT_W-1:0] INTERVAL_NOMINAL = 14'h2edf;
  localparam int unsigned SOF_FLAG_BIT = 2;
  localparam int unsigned CLK_HZ = 100000000;
  localparam int unsigned BIT_RATE_HZ = 12000000;
  localparam int unsigned BIT_TIME_CYCLES = CLK_HZ / BIT_RATE_HZ;
endpackage

// *** design/frame_timing.sv ***
// Purpose: frame number, frame boundary sequencing and periodic start priority
// Assumes: register port synchronous to clk, one-cycle read and write strobes
// Notes: start token send and shared area write use request/done handshakes
`timescale 1ns/1ps
`default_nettype none
module frame_timing #(
  parameter int unsigned BIT_DIV = frame_timing_pkg::BIT_TIME_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [frame_timing_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  output logic reg_hit,
  input wire logic operational_bus_state,
  input wire logic [frame_timing_pkg::COUNT_W-1:0] interval_bit_times,
  input wire logic xfer_busy,
  output logic [frame_timing_pkg::COUNT_W-1:0] remaining_bit_times,
  output logic sof_send,
  input wire logic sof_done,
  output logic comm_write_req,
  output logic [15:0] comm_write_data,
  input wire logic comm_write_done,
  output logic start_of_frame_flag,
  input wire logic sof_flag_clear,
  output logic desc_fetch_ok,
  output logic periodic_priority
);
  import frame_timing_pkg::*;

  if (BIT_DIV < 2 || BIT_DIV > 256) begin : g_div_check
    $error("BIT_DIV must be between 2 and 256");
  end

  typedef enum logic [1:0] {IDLE, SEND_SOF, WRITE_COMM, RUN} seq_e;

  // ****************************
  // bit time enable
  // ****************************
  logic [7:0] div_r;
  logic bit_tick;
  assign bit_tick = (div_r == 8'(BIT_DIV - 1));

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_r <= 8'h00;
    end else if (bit_tick) begin
      div_r <= 8'h00;
    end else begin
      div_r <= div_r + 8'h01;
    end
  end

  // ****************************
  // frame remaining and frame number
  // ****************************
  logic oper_d_r;
  logic enter_oper;
  logic reload;
  logic [COUNT_W-1:0] frame_count_r;
  logic [COUNT_W-1:0] threshold_r;
  seq_e seq_r;

  assign enter_oper = operational_bus_state && !oper_d_r;
  assign reload = operational_bus_state && bit_tick && (remaining_bit_times == 14'h0000);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      oper_d_r <= 1'b0;
    end else begin
      oper_d_r <= operational_bus_state;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      remaining_bit_times <= 14'h0000;
    end else if (enter_oper || reload) begin
      remaining_bit_times <= interval_bit_times;
    end else if (operational_bus_state && bit_tick) begin
      remaining_bit_times <= remaining_bit_times - 14'h0001;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      frame_count_r <= FRAME_NUMBER_RESET;
    end else if (enter_oper || reload) begin
      frame_count_r <= frame_count_r + 14'h0001;
    end else if (reg_wr && reg_addr == OFF_FRAME_NUMBER) begin
      frame_count_r <= reg_wdata[COUNT_W-1:0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      threshold_r <= PERIODIC_START_RESET;
    end else if (reg_wr && reg_addr == OFF_PERIODIC_START) begin
      threshold_r <= reg_wdata[COUNT_W-1:0];
    end
  end

  // ****************************
  // frame boundary sequence
  // ****************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      seq_r <= IDLE;
      sof_send <= 1'b0;
      comm_write_req <= 1'b0;
      comm_write_data <= 16'h0000;
      desc_fetch_ok <= 1'b0;
    end else if (!operational_bus_state) begin
      seq_r <= IDLE;
      sof_send <= 1'b0;
      comm_write_req <= 1'b0;
      desc_fetch_ok <= 1'b0;
    end else begin
      unique case (seq_r)
        IDLE, RUN: begin
          if (enter_oper || reload) begin
            seq_r <= SEND_SOF;
            sof_send <= 1'b1;
            desc_fetch_ok <= 1'b0;
          end
        end
        SEND_SOF: begin
          if (sof_done) begin
            seq_r <= WRITE_COMM;
            sof_send <= 1'b0;
            comm_write_req <= 1'b1;
            comm_write_data <= {2'b00, frame_count_r};
          end
        end
        WRITE_COMM: begin
          if (comm_write_done) begin
            seq_r <= RUN;
            comm_write_req <= 1'b0;
            desc_fetch_ok <= 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      start_of_frame_flag <= 1'b0;
    end else if (seq_r == WRITE_COMM && comm_write_done && operational_bus_state) begin
      start_of_frame_flag <= 1'b1;
    end else if (sof_flag_clear) begin
      start_of_frame_flag <= 1'b0;
    end
  end

  // ****************************
  // periodic priority
  // ****************************
  logic past_threshold_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      past_threshold_r <= 1'b0;
    end else if (!operational_bus_state || enter_oper || reload) begin
      past_threshold_r <= 1'b0;
    end else if (remaining_bit_times == threshold_r) begin
      past_threshold_r <= 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      periodic_priority <= 1'b0;
    end else if (!past_threshold_r) begin
      periodic_priority <= 1'b0;
    end else if (!xfer_busy) begin
      periodic_priority <= 1'b1;
    end
  end

  // ****************************
  // register read port
  // ****************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 32'h00000000;
      reg_hit <= 1'b0;
    end else begin
      reg_hit <= (reg_rd || reg_wr)
        && (reg_addr == OFF_FRAME_NUMBER || reg_addr == OFF_PERIODIC_START);
      if (reg_rd && reg_addr == OFF_FRAME_NUMBER) begin
        reg_rdata <= {18'h00000, frame_count_r};
      end else if (reg_rd && reg_addr == OFF_PERIODIC_START) begin
        reg_rdata <= {18'h00000, threshold_r};
      end else begin
        reg_rdata <= 32'h00000000;
      end
    end
  end

  // ****************************
  // checks
  // ****************************
  property p_fn_inc;
    @(posedge clk) disable iff (rst)
    (enter_oper || reload) |=> frame_count_r == $past(frame_count_r) + 14'h0001;
  endproperty
  a_fn_inc: assert property (p_fn_inc) else $error("frame count did not advance");

  property p_fn_wrap;
    @(posedge clk) disable iff (rst)
    (reload && frame_count_r == 14'h3fff) |=> frame_count_r == 14'h0000;
  endproperty
  a_fn_wrap: assert property (p_fn_wrap) else $error("frame count did not wrap");

  property p_oper_inc;
    @(posedge clk) disable iff (rst)
    $rose(operational_bus_state) |=> frame_count_r != $past(frame_count_r);
  endproperty
  a_oper_inc: assert property (p_oper_inc) else $error("no advance on operational entry");

  property p_order;
    @(posedge clk) disable iff (rst)
    $rose(comm_write_req) |-> !desc_fetch_ok && $past(sof_send);
  endproperty
  a_order: assert property (p_order) else $error("boundary sequence out of order");

  property p_sof_flag;
    @(posedge clk) disable iff (rst)
    (seq_r == WRITE_COMM && comm_write_done && operational_bus_state)
      |=> start_of_frame_flag && desc_fetch_ok;
  endproperty
  a_sof_flag: assert property (p_sof_flag) else $error("start-of-frame flag not set");

  property p_thr_reset;
    @(posedge clk) $fell(rst) |-> threshold_r == 14'h0000;
  endproperty
  a_thr_reset: assert property (p_thr_reset) else $error("threshold not cleared by reset");

  property p_prio_wait;
    @(posedge clk) disable iff (rst)
    (past_threshold_r && xfer_busy && !periodic_priority) |=> !periodic_priority;
  endproperty
  a_prio_wait: assert property (p_prio_wait) else $error("priority taken mid transaction");

  property p_prio_take;
    @(posedge clk) disable iff (rst)
    (past_threshold_r && !xfer_busy) |=> periodic_priority || !past_threshold_r;
  endproperty
  a_prio_take: assert property (p_prio_take) else $error("priority not taken");

  property p_remaining;
    @(posedge clk) disable iff (rst)
    (operational_bus_state && bit_tick && !reload && !enter_oper)
      |=> remaining_bit_times == $past(remaining_bit_times) - 14'h0001;
  endproperty
  a_remaining: assert property (p_remaining) else $error("remaining count not decremented");

  property p_rd_fn;
    @(posedge clk) disable iff (rst)
    (reg_rd && reg_addr == OFF_FRAME_NUMBER) |=> reg_rdata[31:14] == 18'h00000;
  endproperty
  a_rd_fn: assert property (p_rd_fn) else $error("reserved bits read nonzero");

  property p_c_wrap;
    @(posedge clk) disable iff (rst) reload && frame_count_r == 14'h3fff;
  endproperty
  c_wrap: cover property (p_c_wrap);
  property p_c_flag;
    @(posedge clk) disable iff (rst) $rose(start_of_frame_flag);
  endproperty
  c_flag: cover property (p_c_flag);
  property p_c_prio;
    @(posedge clk) disable iff (rst) past_threshold_r && xfer_busy ##[1:64] periodic_priority;
  endproperty
  c_prio: cover property (p_c_prio);
endmodule
`default_nettype wire

// *** tb/host_side_model.sv ***
// Purpose: far side of the frame link, answers start token and shared area write
// Assumes: done pulses last one cycle and are launched 1 ns after the rising edge
// Notes: lat sets the answer delay in cycles, 0 answers promptly
`timescale 1ns/1ps
`default_nettype none
module host_side_model (
  input wire logic clk,
  input wire logic [3:0] lat,
  input wire logic sof_send,
  output logic sof_done,
  input wire logic comm_write_req,
  output logic comm_write_done
);
  initial begin
    sof_done = 1'b0;
    comm_write_done = 1'b0;
  end
  // start token sent after lat cycles
  always begin
    @(posedge clk);
    #1;
    if (sof_send === 1'b1) begin
      repeat (lat) begin
        @(posedge clk);
        #1;
      end
      sof_done = 1'b1;
      @(posedge clk);
      #1;
      sof_done = 1'b0;
    end
  end
  // shared area write finished after lat cycles
  always begin
    @(posedge clk);
    #1;
    if (comm_write_req === 1'b1) begin
      repeat (lat) begin
        @(posedge clk);
        #1;
      end
      comm_write_done = 1'b1;
      @(posedge clk);
      #1;
      comm_write_done = 1'b0;
    end
  end
endmodule
`default_nettype wire

// *** tb/tb.sv ***
// Purpose: self-checking bench for frame_timing
// Assumes: BIT_DIV 2 and a short frame interval keep the run brief
// Notes: inputs change 1 ns after the rising edge
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin num_errors++; \
  $display("ERROR %s expected %h seen %h", nm, e, g); end end
module tb;
  import frame_timing_pkg::*;
  localparam int DIV = 2;
  localparam logic [COUNT_W-1:0] IVL = 14'h001e;
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, op = 1'b0, busy = 1'b0, clr = 1'b0;
  logic [ADDR_W-1:0] addr = '0;
  logic [31:0] wdata = '0, rdata, rv;
  logic hit, hv, sof_send, sof_done, cw_req, cw_done, flag, dfo, prio;
  logic [COUNT_W-1:0] rem;
  logic [15:0] cw_data, fv;
  logic [3:0] lat = 4'h0;
  int num_errors = 0, n_compared = 0;
  time t_req, t0;
  always #5 clk = ~clk;
  frame_timing #(.BIT_DIV(DIV)) frame_timing_i (.clk(clk), .rst(rst), .reg_wr(wr),
    .reg_rd(rd), .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata), .reg_hit(hit),
    .operational_bus_state(op), .interval_bit_times(IVL), .xfer_busy(busy),
    .remaining_bit_times(rem), .sof_send(sof_send), .sof_done(sof_done),
    .comm_write_req(cw_req), .comm_write_data(cw_data), .comm_write_done(cw_done),
    .start_of_frame_flag(flag), .sof_flag_clear(clr), .desc_fetch_ok(dfo),
    .periodic_priority(prio));
  host_side_model host_side_model_i (.clk(clk), .lat(lat), .sof_send(sof_send),
    .sof_done(sof_done), .comm_write_req(cw_req), .comm_write_done(cw_done));
  task automatic step;
    @(posedge clk);
    #1;
  endtask
  task automatic reg_write(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    step;
    wr = 1'b1;
    addr = a;
    wdata = d;
    step;
    wr = 1'b0;
  endtask
  task automatic reg_read(input logic [ADDR_W-1:0] a, output logic [31:0] d, output logic h);
    step;
    rd = 1'b1;
    addr = a;
    step;
    rd = 1'b0;
    d = rdata;
    h = hit;
  endtask
  task automatic wait_frame(output logic [15:0] d);
    int i;
    i = 0;
    while (cw_req !== 1'b1 && i < 500) begin
      step;
      i++;
    end
    t_req = $time;
    d = cw_data;
    `CHK("write_request", 1'b1, cw_req)
    `CHK("sof_before_write", 1'b0, sof_send)
    `CHK("fetch_after_write", 1'b0, dfo)
    `CHK("flag_before_write", 1'b0, flag)
    i = 0;
    while (flag !== 1'b1 && i < 50) begin
      step;
      i++;
    end
    `CHK("sof_flag", 1'b1, flag)
    `CHK("fetch_allowed", 1'b1, dfo)
    step;
    clr = 1'b1;
    step;
    clr = 1'b0;
    `CHK("sof_flag_cleared", 1'b0, flag)
  endtask
  task automatic t_regs;
    reg_read(OFF_FRAME_NUMBER, rv, hv);
    `CHK("frame_number_reset", 32'h0000_0000, rv)
    `CHK("frame_number_hit", 1'b1, hv)
    reg_read(OFF_PERIODIC_START, rv, hv);
    `CHK("periodic_start_reset", 32'h0000_0000, rv)
    reg_write(OFF_PERIODIC_START, 32'h0000_3e67);
    reg_write(8'h44, 32'h0000_1234);
    reg_read(8'h44, rv, hv);
    `CHK("unmapped_hit", 1'b0, hv)
    `CHK("unmapped_rdata", 32'h0000_0000, rv)
    reg_read(OFF_PERIODIC_START, rv, hv);
    `CHK("periodic_start_rw", 32'h0000_3e67, rv)
  endtask
  task automatic t_start;
    op = 1'b1;
    wait_frame(fv);
    `CHK("count_on_entry", 16'h0001, fv)
    wait_frame(fv);
    t0 = t_req;
    `CHK("count_on_reload", 16'h0002, fv)
    wait_frame(fv);
    `CHK("frame_period", 64'((IVL + 1) * DIV * 10), t_req - t0)
  endtask
  task automatic t_wrap;
    logic [31:0] ext;
    reg_write(OFF_FRAME_NUMBER, 32'h0000_3fff);
    reg_read(OFF_FRAME_NUMBER, rv, hv);
    `CHK("count_written", 32'h0000_3fff, rv)
    lat = 4'h5;
    wait_frame(fv);
    `CHK("count_wrapped", 16'h0000, fv)
    ext = (fv[13:0] < rv[13:0]) ? 32'h0000_4000 : 32'h0000_0000;
    ext = ext | {18'h0, fv[13:0]};
    `CHK("extended_count", 32'h0000_4000, ext)
  endtask
  task automatic t_prio;
    int i;
    reg_write(OFF_PERIODIC_START, 32'h0000_000a);
    busy = 1'b1;
    i = 0;
    while (rem !== 14'h000a && i < 200) begin
      step;
      i++;
    end
    repeat (4) step;
    `CHK("prio_while_busy", 1'b0, prio)
    `CHK("remaining_two_ticks", 14'h0008, rem)
    busy = 1'b0;
    repeat (2) step;
    `CHK("prio_after_busy", 1'b1, prio)
    wait_frame(fv);
    `CHK("prio_cleared", 1'b0, prio)
  endtask
  task automatic t_reset;
    op = 1'b0;
    repeat (2) step;
    `CHK("fetch_abort", 1'b0, dfo)
    rst = 1'b1;
    repeat (3) step;
    rst = 1'b0;
    reg_read(OFF_PERIODIC_START, rv, hv);
    `CHK("periodic_start_rst", 32'h0000_0000, rv)
    reg_read(OFF_FRAME_NUMBER, rv, hv);
    `CHK("frame_number_rst", 32'h0000_0000, rv)
    op = 1'b1;
    wait_frame(fv);
    `CHK("count_reentry", 16'h0001, fv)
  endtask
  task automatic final_report;
    if (num_errors == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk);
    #1 rst = 1'b0;
    t_regs;
    t_start;
    t_wrap;
    t_prio;
    t_reset;
    final_report;
  end
  initial begin
    #100000;
    num_errors++;
    final_report;
  end
endmodule
`default_nettype wire
